/* core/smp_defines.svh */
/*
  Message codes, format ranges and counts shared by the message parser.
  Assumes it is included by bare name from any file that needs a code.
*/
`ifndef SMP_DEFINES_SVH
`define SMP_DEFINES_SVH

`define SMP_TASK_COMPLETE   8'h00
`define SMP_EXT_INTRO       8'h01
`define SMP_ONE_A_LO        8'h02
`define SMP_ONE_A_HI        8'h0A
`define SMP_ONE_B_LO        8'h0C
`define SMP_ONE_B_HI        8'h0E
`define SMP_ONE_C_LO        8'h16
`define SMP_ONE_C_HI        8'h17
`define SMP_QAS_REQ         8'h55
`define SMP_TWO_LO          8'h20
`define SMP_TWO_HI          8'h24
`define SMP_ATTR_LO         8'h20
`define SMP_ATTR_HI         8'h22
`define SMP_IDENT_BIT       7
`define SMP_ABORT_TASK_SET  8'h06
`define SMP_TARGET_RESET    8'h0C
`define SMP_LUN_W           3

`define SMP_EXT_MDP         8'h00
`define SMP_EXT_SDTR        8'h01
`define SMP_EXT_WDTR        8'h03
`define SMP_EXT_PPR         8'h04
`define SMP_EXT_MBDP        8'h05

`define SMP_CNT_W           9
`define SMP_LEN_ZERO_BYTES  9'h100
`define SMP_TWO_FOLLOW      9'h001
`define SMP_CNT_ONE         9'h001

`endif

/* core/smp_pkg.sv */
/*
  Types of the message parser: parser states and message formats.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package smp_pkg;
  typedef enum logic [1:0] {
    SMP_IDLE    = 2'b00,
    SMP_EXT_LEN = 2'b01,
    SMP_BODY    = 2'b10
  } smp_state_t;

  typedef enum logic [2:0] {
    SMP_FMT_ONE   = 3'b000,
    SMP_FMT_TWO   = 3'b001,
    SMP_FMT_EXT   = 3'b010,
    SMP_FMT_IDENT = 3'b011,
    SMP_FMT_RSVD  = 3'b100
  } smp_fmt_t;
endpackage : smp_pkg

/* core/smp_message_parser.sv */
/*
  Target-side message-out parser: frames one-byte, two-byte and extended
  messages, polices the first messages of a connection and raises bus free,
  reject, restore-pointers, identify and dt-data requests as pulses.
  Assumes the phase sequencer hands over one byte in each clock cycle that byte_valid is high while
  msg_out_phase is high, and reports selection/reselection as single pulses.
*/
// Contract
// - a message never spans two message phases; a split one forces bus free
// - several complete messages may follow back to back in one phase
// - any other first message without IU agreement forces unexpected bus free
// - with tagged queuing a task attribute must directly follow identify
// - without IU agreement target sends identify first after reselection
// - second identify naming another unit in a connection forces bus free
// - with IU agreement target goes straight to DT data after reselection
// - reselection or a good L_Q unit implies a restore-pointers operation
// - first byte classifies: 00h task complete, 01h extended, 80h-FFh identify
// - 02h-0Ah, 0Ch-0Eh, 16h-17h and 55h are complete one-byte messages
// - 20h-24h are two-byte messages: code then parameter, same phase
// - an extended message has at least three bytes
// - all extended bytes arrive within one message-out phase
// - extended layout: 01h, length, code, arguments; length covers code and args
// - total extended length is the length field plus two
// - length field zero means 256 bytes follow
// - extended codes 00h,01h,03h,04h,05h known; 02h and 06h-FFh reserved
// - every mandatory message of the role is implemented
// - unsupported, reserved or obsolete messages are answered with reject
`timescale 1ns/1ps
`default_nettype none
`include "smp_defines.svh"

module smp_message_parser #(
  parameter int LUN_W = `SMP_LUN_W
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              msg_out_phase,
  input  wire logic              byte_valid,
  input  wire logic [7:0]        byte_data,
  input  wire logic              sel_atn,
  input  wire logic              resel,
  input  wire logic              lq_ok,
  input  wire logic              iu_agree,
  input  wire logic              tagged_q,
  output logic                   msg_done,
  output smp_pkg::smp_fmt_t      msg_kind,
  output logic [7:0]             msg_code,
  output logic [7:0]             msg_ext_code,
  output logic [7:0]             msg_param,
  output logic                   msg_reject,
  output logic                   force_bus_free,
  output logic                   restore_ptrs,
  output logic                   send_identify,
  output logic                   enter_dt_data,
  output logic [LUN_W-1:0]       cur_lun
);
  import smp_pkg::*;

  // lun field sits below the identify bit, so it cannot be wider than it
  if (LUN_W < 1 || LUN_W > `SMP_IDENT_BIT)
  begin : g_lun_chk
    $error("LUN_W must lie between 1 and 7");
  end

  typedef struct packed {
    smp_state_t              st;
    logic [`SMP_CNT_W-1:0]   cnt;
    logic                    code_taken;
    logic                    first_pend;
    logic                    attr_pend;
    logic                    lun_valid;
    logic [LUN_W-1:0]        lun;
    smp_fmt_t                kind;
    logic [7:0]              code;
    logic [7:0]              ext;
    logic [7:0]              param;
    logic                    done;
    logic                    reject;
    logic                    bus_free;
    logic                    restore;
    logic                    send_id;
    logic                    dt_data;
  } smp_regs_t;

  smp_regs_t s;
  smp_regs_t next_s;

  function automatic logic in_rng(input logic [7:0] b, input logic [7:0] lo,
                                  input logic [7:0] hi);
    return (b >= lo) && (b <= hi);
  endfunction : in_rng

  function automatic smp_fmt_t classify(input logic [7:0] b);
    if (b[`SMP_IDENT_BIT])
      return SMP_FMT_IDENT;
    else if (b == `SMP_EXT_INTRO)
      return SMP_FMT_EXT;
    else if (b == `SMP_TASK_COMPLETE || in_rng(b, `SMP_ONE_A_LO, `SMP_ONE_A_HI) ||
             in_rng(b, `SMP_ONE_B_LO, `SMP_ONE_B_HI) ||
             in_rng(b, `SMP_ONE_C_LO, `SMP_ONE_C_HI) || b == `SMP_QAS_REQ)
      return SMP_FMT_ONE;
    else if (in_rng(b, `SMP_TWO_LO, `SMP_TWO_HI))
      return SMP_FMT_TWO;
    else
      return SMP_FMT_RSVD;
  endfunction : classify

  function automatic logic ext_known(input logic [7:0] c);
    return c == `SMP_EXT_MDP || c == `SMP_EXT_SDTR || c == `SMP_EXT_WDTR ||
           c == `SMP_EXT_PPR || c == `SMP_EXT_MBDP;
  endfunction : ext_known

  logic        take;
  logic        fin;
  smp_fmt_t    fkind;
  logic [7:0]  fcode;
  logic [7:0]  fext;

  assign take = byte_valid && msg_out_phase;

  always_comb begin
    next_s         = s;
    next_s.done    = 1'b0;
    next_s.reject  = 1'b0;
    next_s.bus_free = 1'b0;
    next_s.restore = 1'b0;
    next_s.send_id = 1'b0;
    next_s.dt_data = 1'b0;
    fin            = 1'b0;
    fkind          = s.kind;
    fcode          = s.code;
    fext           = s.ext;
    if (sel_atn) begin
      next_s.st         = SMP_IDLE;
      next_s.first_pend = !iu_agree;
      next_s.attr_pend  = 1'b0;
      next_s.lun_valid  = 1'b0;
    end else if (resel) begin
      next_s.st        = SMP_IDLE;
      next_s.first_pend = 1'b0;
      next_s.attr_pend = 1'b0;
      next_s.lun_valid = 1'b0;
      next_s.restore   = 1'b1;
      next_s.send_id   = !iu_agree;
      next_s.dt_data   = iu_agree;
    end else if (!msg_out_phase && s.st != SMP_IDLE) begin
      // phase left with a message half read
      next_s.st       = SMP_IDLE;
      next_s.bus_free = 1'b1;
    end else if (take) begin
      unique case (s.st)
        SMP_IDLE:
        begin
          fkind             = classify(byte_data);
          fcode             = byte_data;
          next_s.kind       = fkind;
          next_s.code       = byte_data;
          next_s.ext        = 8'h00;
          next_s.param      = 8'h00;
          next_s.code_taken = 1'b0;
          if (fkind == SMP_FMT_EXT)
            next_s.st = SMP_EXT_LEN;
          else if (fkind == SMP_FMT_TWO)
          begin
            next_s.st  = SMP_BODY;
            next_s.cnt = `SMP_TWO_FOLLOW;
          end
          else
            fin = 1'b1;
        end
        SMP_EXT_LEN:
        begin
          next_s.st  = SMP_BODY;
          // length plus two in total: two already seen
          next_s.cnt = (byte_data == 8'h00) ? `SMP_LEN_ZERO_BYTES
                                            : {1'b0, byte_data};
        end
        SMP_BODY:
        begin
          if (s.kind == SMP_FMT_TWO)
            next_s.param = byte_data;
          else if (!s.code_taken)
          begin
            fext              = byte_data;
            next_s.ext        = byte_data;
            next_s.code_taken = 1'b1;
          end
          next_s.cnt = s.cnt - `SMP_CNT_ONE;
          fin = (s.cnt == `SMP_CNT_ONE);
        end
        default:
          next_s.st = SMP_IDLE;
      endcase
    end
    if (lq_ok)
      next_s.restore = 1'b1;
    if (fin) begin
      next_s.st   = SMP_IDLE;
      next_s.done = 1'b1;
      if (s.first_pend) begin
        next_s.first_pend = 1'b0;
        if (!(fkind == SMP_FMT_IDENT || fcode == `SMP_ABORT_TASK_SET ||
              fcode == `SMP_TARGET_RESET))
          next_s.bus_free = 1'b1;
      end
      if (!next_s.bus_free) begin
        if (fkind == SMP_FMT_IDENT) begin
          if (s.lun_valid && s.lun != fcode[LUN_W-1:0])
            next_s.bus_free = 1'b1;
          else begin
            next_s.lun_valid = 1'b1;
            next_s.lun       = fcode[LUN_W-1:0];
            next_s.attr_pend = tagged_q;
          end
        end else if (s.attr_pend) begin
          next_s.attr_pend = 1'b0;
          // no attribute where one is due: refused, not fatal
          if (!in_rng(fcode, `SMP_ATTR_LO, `SMP_ATTR_HI))
            next_s.reject = 1'b1;
        end
        if (fkind == SMP_FMT_RSVD || (fkind == SMP_FMT_EXT && !ext_known(fext)))
          next_s.reject = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign msg_done       = s.done;
  assign msg_kind       = s.kind;
  assign msg_code       = s.code;
  assign msg_ext_code   = s.ext;
  assign msg_param      = s.param;
  assign msg_reject     = s.reject;
  assign force_bus_free = s.bus_free;
  assign restore_ptrs   = s.restore;
  assign send_identify  = s.send_id;
  assign enter_dt_data  = s.dt_data;
  assign cur_lun        = s.lun;

  property p_first_bad;
    @(posedge clk) disable iff (!rst_n)
      (s.first_pend && take && !sel_atn && !resel && s.st == SMP_IDLE &&
       classify(byte_data) == SMP_FMT_ONE && byte_data != `SMP_ABORT_TASK_SET &&
       byte_data != `SMP_TARGET_RESET) |=> force_bus_free && msg_done;
  endproperty
  a_first_bad: assert property (p_first_bad) else $error("bad first message kept");

  property p_resel_id;
    @(posedge clk) disable iff (!rst_n)
      (resel && !sel_atn && !iu_agree) |=> send_identify && !enter_dt_data;
  endproperty
  a_resel_id: assert property (p_resel_id) else $error("no identify after reselection");

  property p_resel_dt;
    @(posedge clk) disable iff (!rst_n)
      (resel && !sel_atn && iu_agree) |=> enter_dt_data && !send_identify;
  endproperty
  a_resel_dt: assert property (p_resel_dt) else $error("no dt data after reselection");

  property p_restore;
    @(posedge clk) disable iff (!rst_n)
      ((resel && !sel_atn) || lq_ok) |=> restore_ptrs;
  endproperty
  a_restore: assert property (p_restore) else $error("restore pointers missing");

  property p_ext_start;
    @(posedge clk) disable iff (!rst_n)
      (take && !sel_atn && !resel && s.st == SMP_IDLE && byte_data == `SMP_EXT_INTRO)
        |=> s.st == SMP_EXT_LEN && !msg_done;
  endproperty
  a_ext_start: assert property (p_ext_start) else $error("extended start missed");

  property p_two_byte;
    @(posedge clk) disable iff (!rst_n)
      (take && !sel_atn && !resel && s.st == SMP_IDLE &&
       in_rng(byte_data, `SMP_TWO_LO, `SMP_TWO_HI))
        ##1 (take && !sel_atn && !resel) |=> msg_done && msg_kind == SMP_FMT_TWO;
  endproperty
  a_two_byte: assert property (p_two_byte) else $error("two-byte message not closed");

  property p_len_zero;
    @(posedge clk) disable iff (!rst_n)
      (take && !sel_atn && !resel && s.st == SMP_EXT_LEN && byte_data == 8'h00)
        |=> s.cnt == `SMP_LEN_ZERO_BYTES;
  endproperty
  a_len_zero: assert property (p_len_zero) else $error("zero length not 256");

  property p_split;
    @(posedge clk) disable iff (!rst_n)
      (!msg_out_phase && !sel_atn && !resel && s.st != SMP_IDLE)
        |=> force_bus_free && s.st == SMP_IDLE;
  endproperty
  a_split: assert property (p_split) else $error("split message not caught");

  property p_one_byte;
    @(posedge clk) disable iff (!rst_n)
      (take && !sel_atn && !resel && s.st == SMP_IDLE && byte_data == `SMP_QAS_REQ)
        |=> msg_done && msg_code == `SMP_QAS_REQ;
  endproperty
  a_one_byte: assert property (p_one_byte) else $error("one-byte message not closed");
endmodule : smp_message_parser
`default_nettype wire

/* tb/smp_init_model.sv */
/*
  Initiator-side message-out source for the message parser bench.
  Assumes the bench fills q and calls send; inputs move 1 ns after clk.
*/
`timescale 1ns/1ps
`default_nettype none
module smp_init_model (
  input  wire logic       clk,
  output logic            msg_out_phase,
  output logic            byte_valid,
  output logic [7:0]      byte_data
);
  logic [7:0] q[$];
  initial
  begin
    msg_out_phase = 1'b0;
    byte_valid    = 1'b0;
    byte_data     = 8'h5A;
  end
  // cut below size splits the message on purpose
  task automatic send(input int cut, input int gap);
    @(posedge clk);
    #1 msg_out_phase = 1'b1;
    // back-to-back bytes keep byte_valid high: no double drive in one step
    for (int i = 0; i < q.size() && i != cut; i++)
    begin
      if (i > 0 && gap > 0)
      begin
        byte_valid = 1'b0;
        // released bus never keeps the old byte
        byte_data  = ~byte_data;
        repeat (gap) @(posedge clk);
        #1;
      end
      byte_valid = 1'b1;
      byte_data  = q[i];
      @(posedge clk);
      #1;
    end
    byte_valid    = 1'b0;
    byte_data     = ~byte_data;
    msg_out_phase = 1'b0;
    q.delete();
  endtask : send
endmodule : smp_init_model
`default_nettype wire

/* tb/smp_message_parser_test.sv */
/*
  Self-checking bench for the message parser with a reference model.
  Assumes smp_init_model drives the message-out byte stream.
*/
`timescale 1ns/1ps
`default_nettype none
module smp_message_parser_test;
  import smp_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n;
  logic        iu_agree;
  logic        tagged_q;
  logic [2:0]  ev;
  logic        msg_out_phase;
  logic        byte_valid;
  logic [7:0]  byte_data;
  logic        msg_done;
  smp_fmt_t    msg_kind;
  logic [7:0]  msg_code;
  logic [7:0]  msg_ext_code;
  logic [7:0]  msg_param;
  logic        msg_reject;
  logic        force_bus_free;
  logic        restore_ptrs;
  logic        send_identify;
  logic        enter_dt_data;
  logic [2:0]  cur_lun;
  int          fail_count = 0;
  int          compares = 0;
  integer      seed = 32'h07D7;
  int          ptr_act;
  int          ptr_sav = 32'h100;

  always #5 clk = ~clk;

  smp_init_model ini_u (.clk(clk), .msg_out_phase(msg_out_phase), .byte_valid(byte_valid),
    .byte_data(byte_data));
  smp_message_parser dut_u (.clk(clk), .rst_n(rst_n), .msg_out_phase(msg_out_phase),
    .byte_valid(byte_valid), .byte_data(byte_data), .sel_atn(ev[0]), .resel(ev[1]),
    .lq_ok(ev[2]), .iu_agree(iu_agree), .tagged_q(tagged_q), .msg_done(msg_done),
    .msg_kind(msg_kind), .msg_code(msg_code), .msg_ext_code(msg_ext_code),
    .msg_param(msg_param), .msg_reject(msg_reject), .force_bus_free(force_bus_free),
    .restore_ptrs(restore_ptrs), .send_identify(send_identify),
    .enter_dt_data(enter_dt_data), .cur_lun(cur_lun));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  task automatic evt(input logic [2:0] e, input logic iu);
    logic [2:0] want;
    want = {e[1] | e[2], e[1] & !iu, e[1] & iu};
    ptr_act = $random(seed) & 32'hFF;
    iu_agree = iu;
    ev = e;
    @(posedge clk);
    #1 ev = 3'b000;
    chk(32'({restore_ptrs, send_identify, enter_dt_data}), 32'(want));
    // initiator rebuilds its nexus: active pointers take the saved ones
    if (restore_ptrs)
      ptr_act = ptr_sav;
    chk(32'(ptr_act == ptr_sav), 32'(e[1] | e[2]));
    // one quiet edge so the next pulse is a separate drive
    @(posedge clk);
    #1;
  endtask : evt

  task automatic push_ext(input logic [7:0] code, input logic [7:0] len);
    int n;
    n = (len == 8'h00) ? 256 : int'(len);
    ini_u.q = {8'h01, len, code};
    repeat (n - 1) ini_u.q.push_back(8'($random(seed)));
  endtask : push_ext

  // reference decode of the queued message, then compare at msg_done
  task automatic msg(input int cut, input logic bf, input logic rj);
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    smp_fmt_t   k;
    logic       r;
    logic [29:0] got;
    logic [29:0] want;
    b0 = ini_u.q[0];
    b1 = (ini_u.q.size() > 1) ? ini_u.q[1] : 8'h00;
    b2 = (ini_u.q.size() > 2) ? ini_u.q[2] : 8'h00;
    r = 1'b0;
    ini_u.send(cut, $random(seed) & 1);
    if (cut >= 0)
    begin
      @(posedge clk);
      #1 chk(32'({msg_done, force_bus_free}), 32'h1);
      return;
    end
    if (b0[7])
      k = SMP_FMT_IDENT;
    else if (b0 == 8'h01)
    begin
      k = SMP_FMT_EXT;
      r = (b2 == 8'h02) || (b2 > 8'h05);
    end
    else if (b0 >= 8'h20 && b0 <= 8'h24)
      k = SMP_FMT_TWO;
    else if (b0 inside {8'h00, [8'h02:8'h0A], [8'h0C:8'h0E], 8'h16, 8'h17, 8'h55})
      k = SMP_FMT_ONE;
    else
    begin
      k = SMP_FMT_RSVD;
      r = 1'b1;
    end
    got = {msg_done, msg_kind, msg_code, msg_ext_code, msg_param, msg_reject, force_bus_free};
    want = {1'b1, k, b0, (k == SMP_FMT_EXT) ? b2 : 8'h00, (k == SMP_FMT_TWO) ? b1 : 8'h00,
            r | rj, bf};
    chk(32'(got), 32'(want));
  endtask : msg

  initial
  begin
    rst_n = 1'b0;
    iu_agree = 1'b0;
    tagged_q = 1'b0;
    ev = 3'b000;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    // gaps of 0 or 1 cycle exercise back-to-back bytes
    for (int b = 0; b < 128; b++)
      if (!(b inside {1, [24:31], [37:47]}))
      begin
        ini_u.q = {8'(b)};
        if (b >= 32 && b <= 36)
          ini_u.q.push_back(8'($random(seed)));
        msg(-1, 1'b0, 1'b0);
      end
    for (int c = 0; c < 8; c++)
    begin
      push_ext(8'(c), 8'h03);
      msg(-1, 1'b0, 1'b0);
    end
    push_ext(8'h01, 8'h01);
    msg(-1, 1'b0, 1'b0);
    push_ext(8'h04, 8'h00);
    msg(-1, 1'b0, 1'b0);
    evt(3'b010, 1'b0);
    evt(3'b010, 1'b1);
    evt(3'b100, 1'b0);
    evt(3'b001, 1'b0);
    ini_u.q = {8'h08};
    msg(-1, 1'b1, 1'b0);
    evt(3'b001, 1'b0);
    ini_u.q = {8'h06};
    msg(-1, 1'b0, 1'b0);
    evt(3'b001, 1'b0);
    ini_u.q = {8'h0C};
    msg(-1, 1'b0, 1'b0);
    evt(3'b001, 1'b0);
    ini_u.q = {8'h85};
    msg(-1, 1'b0, 1'b0);
    chk(32'(cur_lun), 32'h5);
    ini_u.q = {8'h86};
    msg(-1, 1'b1, 1'b0);
    tagged_q = 1'b1;
    evt(3'b001, 1'b0);
    ini_u.q = {8'h80};
    msg(-1, 1'b0, 1'b0);
    ini_u.q = {8'h08};
    msg(-1, 1'b0, 1'b1);
    evt(3'b001, 1'b0);
    ini_u.q = {8'h80};
    msg(-1, 1'b0, 1'b0);
    ini_u.q = {8'h21, 8'($random(seed))};
    msg(-1, 1'b0, 1'b0);
    tagged_q = 1'b0;
    push_ext(8'h03, 8'h02);
    msg(2, 1'b0, 1'b0);
    test_done();
  end

  // far beyond the fewer than a thousand cycles the sequence needs
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    test_done();
  end
endmodule : smp_message_parser_test
`default_nettype wire
